// >>> verilog/rail_control_cfg.svh
`ifndef RAIL_CONTROL_CFG_SVH
`define RAIL_CONTROL_CFG_SVH
// Register offsets
`define BB_VOLT_OFS        8'h39
`define BB_CTRL_OFS        8'h3A
`define REG_ONE_OFS        8'h3B
// Field positions and widths
`define BB_EN_MSB          7
`define BB_EN_LSB          5
`define BB_PG_EN_POS       3
`define BB_GOOD_POS        1
`define BB_ILIM_POS        0
`define REG_ONE_BYP_POS    6
// Reset values and code limits
`define BB_VOLT_RST        7'h3E
`define BB_VOLT_MAX        7'h46
`define BB_EN_RST          3'h2
`define BB_PG_EN_RST       1'h1
`define BB_ILIM_RST        1'h0
`define REG_ONE_VOLT_RST   6'h14
`define REG_ONE_VOLT_MAX   6'h38
`define REG_ONE_BYP_RST    1'h0
`endif

// >>> verilog/rail_control_pkg.sv
`default_nettype none
package rail_control_pkg;
  typedef enum logic [2:0] {
    EN_SLOT_A   = 3'h0,
    EN_SLOT_B   = 3'h1,
    EN_SLOT_C   = 3'h2,
    EN_SLOT_D   = 3'h3,
    EN_HOLD_OFF = 3'h4,
    EN_HOLD_ON  = 3'h5,
    EN_PIN_CTRL = 3'h6,
    EN_RESERVED = 3'h7
  } bb_enable_t;
endpackage
`default_nettype wire

// >>> verilog/code_clamp.sv
`default_nettype none
// Saturates a written code to the highest legal value
module code_clamp #(
  parameter int W = 7
) (
  input  wire logic [W-1:0] code_i,
  input  wire logic [W-1:0] max_i,
  output logic      [W-1:0] code_o
);
  assign code_o = (code_i > max_i) ? max_i : code_i;
endmodule // code_clamp
`default_nettype wire

// >>> verilog/rail_control_regs.sv
`include "rail_control_cfg.svh"
`default_nettype none
module rail_control_regs
  import rail_control_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       reg_reset_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rd_hit_o,
  input  wire logic       bb_good_i,
  input  wire logic       second_general_pin_i,
  output logic      [6:0] bb_voltage_code_o,
  output logic            bb_in_sequence_o,
  output logic      [1:0] bb_slot_o,
  output logic            bb_force_on_o,
  output logic            bb_good_supervise_on_o,
  output logic            bb_input_limit_sel_o,
  output logic      [5:0] reg_one_voltage_code_o,
  output logic            reg_one_bypass_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0] bb_volt_r;
  logic [2:0] bb_en_r;
  logic       bb_pg_en_r;
  logic       bb_ilim_r;
  logic [5:0] one_volt_r;
  logic       one_byp_r;
  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       good_s1_r;
  logic       good_s2_r;
  logic [6:0] bb_volt_nxt;
  logic [5:0] one_volt_nxt;
  logic       wr_bb_volt;
  logic       wr_bb_ctrl;
  logic       wr_one;
  bb_enable_t bb_en_mode;

  assign wr_bb_volt = ce_i && wr_en_i && (addr_i == `BB_VOLT_OFS);
  assign wr_bb_ctrl = ce_i && wr_en_i && (addr_i == `BB_CTRL_OFS);
  assign wr_one     = ce_i && wr_en_i && (addr_i == `REG_ONE_OFS);
  assign bb_en_mode = bb_enable_t'(bb_en_r);

  code_clamp #(.W(7)) u_bb_clamp (
    .code_i (wdata_i[6:0]),
    .max_i  (`BB_VOLT_MAX),
    .code_o (bb_volt_nxt)
  );
  code_clamp #(.W(6)) u_one_clamp (
    .code_i (wdata_i[5:0]),
    .max_i  (`REG_ONE_VOLT_MAX),
    .code_o (one_volt_nxt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // voltage code reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bb_volt_r <= `BB_VOLT_RST;
    else if (ce_i && reg_reset_i)
      bb_volt_r <= `BB_VOLT_RST;
    else if (wr_bb_volt)
      bb_volt_r <= bb_volt_nxt;
  end

  // enable select, reset 2h; fields share the command
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && reg_reset_i))
    begin
      bb_en_r    <= `BB_EN_RST;
      bb_pg_en_r <= `BB_PG_EN_RST;
      bb_ilim_r  <= `BB_ILIM_RST;
    end
    else if (wr_bb_ctrl)
    begin
      bb_en_r    <= wdata_i[`BB_EN_MSB:`BB_EN_LSB];
      bb_pg_en_r <= wdata_i[`BB_PG_EN_POS];
      bb_ilim_r  <= wdata_i[`BB_ILIM_POS];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && reg_reset_i))
      one_volt_r <= `REG_ONE_VOLT_RST;
    else if (wr_one)
      one_volt_r <= one_volt_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      one_byp_r <= `REG_ONE_BYP_RST;
    else if (wr_one)
      one_byp_r <= wdata_i[`REG_ONE_BYP_POS];
  end

  // Pin and analog status come from outside the clock domain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r  <= 1'h0;
      pin_s2_r  <= 1'h0;
      good_s1_r <= 1'h0;
      good_s2_r <= 1'h0;
    end
    else if (ce_i)
    begin
      pin_s1_r  <= second_general_pin_i;
      pin_s2_r  <= pin_s1_r;
      good_s1_r <= bb_good_i;
      good_s2_r <= good_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence membership and slot
  always_comb
  begin
    bb_in_sequence_o = 1'b0;
    bb_slot_o        = bb_en_r[1:0];
    bb_force_on_o    = 1'b0;
    unique case (bb_en_mode)
      EN_SLOT_A, EN_SLOT_B, EN_SLOT_C, EN_SLOT_D:
        bb_in_sequence_o = 1'b1;
      EN_HOLD_OFF: bb_force_on_o = 1'b0;
      EN_HOLD_ON:  bb_force_on_o = 1'b1;
      EN_PIN_CTRL: bb_force_on_o = pin_s2_r;
      // Reserved code keeps the rail off as the safe choice
      EN_RESERVED: bb_force_on_o = 1'b0;
    endcase
  end

  assign bb_voltage_code_o      = bb_volt_r;
  assign bb_good_supervise_on_o = bb_pg_en_r;
  assign bb_input_limit_sel_o   = bb_ilim_r;
  assign reg_one_voltage_code_o = one_volt_r;
  assign reg_one_bypass_sel_o   = one_byp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered one cycle after rd_en_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o  <= 8'h00;
      rd_hit_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_hit_o <= rd_en_i;
      if (rd_en_i)
      begin
        unique case (addr_i)
          `BB_VOLT_OFS: rdata_o <= {1'b0, bb_volt_r};
          `BB_CTRL_OFS: rdata_o <= {bb_en_r, 1'b0, bb_pg_en_r, 1'b0, good_s2_r, bb_ilim_r};
          `REG_ONE_OFS: rdata_o <= {1'b0, one_byp_r, one_volt_r};
          default:      rdata_o <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  bb_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_bb_volt && !reg_reset_i |=> bb_volt_r <= `BB_VOLT_MAX) else $error("bb code above max");
  bb_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_bb_volt && !reg_reset_i && wdata_i[6:0] <= `BB_VOLT_MAX |=> bb_volt_r == $past(wdata_i[6:0]))
    else $error("bb code not stored");
  bb_cmd_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reg_reset_i |=> bb_volt_r == `BB_VOLT_RST && bb_en_r == `BB_EN_RST && bb_pg_en_r
    && !bb_ilim_r) else $error("command reset missed");
  slot_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bb_en_r[2] == 1'b0 |-> bb_in_sequence_o && bb_slot_o == bb_en_r[1:0]) else $error("slot wrong");
  hold_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bb_en_r[2] |-> !bb_in_sequence_o && (bb_en_r == 3'h5 ? bb_force_on_o : bb_en_r != 3'h6 ? !bb_force_on_o : 1'b1))
    else $error("hold wrong");
  // Synchroniser must have shifted twice out of reset before the pin is compared
  pin_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2) && bb_en_r == 3'h6
    |-> bb_force_on_o == $past(second_general_pin_i, 2)) else $error("pin not followed");
  good_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_en_i && addr_i == `BB_CTRL_OFS |=> rdata_o[`BB_GOOD_POS] == $past(good_s2_r)
    && rdata_o[`BB_PG_EN_POS] == $past(bb_pg_en_r)) else $error("status read wrong");
  one_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_one && !reg_reset_i && wdata_i[5:0] > `REG_ONE_VOLT_MAX |=> one_volt_r == `REG_ONE_VOLT_MAX)
    else $error("reg one not clamped");
  byp_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reg_reset_i && !wr_one |=> one_byp_r == $past(one_byp_r)) else $error("bypass reset by command");
  rsv_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_hit_o |-> !rdata_o[7] || ($past(addr_i) == `BB_CTRL_OFS)) else $error("reserved bit set");

  cov_pin_c:   cover property (@(posedge clk_i) bb_en_r == 3'h6 && bb_force_on_o);
  cov_clamp_c: cover property (@(posedge clk_i) wr_bb_volt && wdata_i[6:0] > `BB_VOLT_MAX);
  cov_cmd_c:   cover property (@(posedge clk_i) ce_i && reg_reset_i);
  cov_cmd_wr_c: cover property (@(posedge clk_i) ce_i && reg_reset_i && wr_en_i);

endmodule // rail_control_regs
`default_nettype wire

// >>> bench/host_model.sv
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rd_hit_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // Address and data turn to junk once released, so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic hit);
    @(negedge clk_i);
    addr_o  = a;
    rd_en_o = 1'b1;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    addr_o  = ~a;
    hit     = rd_hit_i;
    d       = rdata_i;
  endtask
endmodule // host_model
`default_nettype wire

// >>> bench/rail_control_regs_tb.sv
`default_nettype none
module rail_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, reg_reset_i = 1'b0, good = 1'b0, pin = 1'b0;
  logic wr_en_i, rd_en_i, rd_hit_o, in_seq, force_on, pg_on, ilim, byp;
  logic [7:0] addr_i, wdata_i, rdata_o, w, a;
  logic [6:0] bb_code;
  logic [5:0] r1_code;
  logic [1:0] slot;
  logic [7:0] mdl [4];
  logic [31:0] s = 32'h08F2;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  rail_control_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_reset_i(reg_reset_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rd_hit_o(rd_hit_o), .bb_good_i(good), .second_general_pin_i(pin), .bb_voltage_code_o(bb_code),
    .bb_in_sequence_o(in_seq), .bb_slot_o(slot), .bb_force_on_o(force_on), .bb_good_supervise_on_o(pg_on),
    .bb_input_limit_sel_o(ilim), .reg_one_voltage_code_o(r1_code), .reg_one_bypass_sel_o(byp));
  host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .rd_hit_i(rd_hit_o), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] stored(input logic [7:0] ad, input logic [7:0] d);
    case (ad)
      8'h39: return (d[6:0] > 7'h46) ? 8'h46 : {1'b0, d[6:0]};
      8'h3A: return d & 8'hE9;
      8'h3B: return {1'b0, d[6], (d[5:0] > 6'h38) ? 6'h38 : d[5:0]};
      default: return mdl[ad[1:0]];
    endcase
  endfunction
  function automatic logic [31:0] exp_out();
    logic [2:0] en;
    en = mdl[2][7:5];
    return {12'h000, mdl[1][6:0], en < 3'h4, en[1:0], (en == 3'h5) | ((en == 3'h6) & pin),
            mdl[2][3], mdl[2][0], mdl[3][5:0], mdl[3][6]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] ad);
    logic [7:0] d;
    logic       h;
    host.rd(ad, d, h);
    chk("rd_hit", {31'h0, h}, 32'h1);
    chk("rdata", {24'h0, d}, {24'h0, mdl[ad[1:0]] | ((ad == 8'h3A) ? {6'h00, good, 1'b0} : 8'h00)});
    chk("outputs", {12'h000, bb_code, in_seq, slot, force_on, pg_on, ilim, r1_code, byp}, exp_out());
    // Read acknowledge stands for one cycle only
    @(negedge clk_i);
    chk("rd_hit_low", {31'h0, rd_hit_o}, 32'h0);
  endtask
  task automatic por();
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    mdl = '{8'h00, 8'h3E, 8'h48, 8'h14};
  endtask
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    por();
    // Power-on values and unmapped read
    for (int i = 0; i < 4; i++) rchk(8'h38 + 8'(i));
    // Every enable code, clamp corners, then random traffic
    for (int i = 0; i < 60; i++)
    begin
      s = lfsr(s);
      good = s[12];
      pin = s[13];
      a = (i < 8) ? 8'h3A : 8'h38 + {6'h00, s[9:8]};
      w = (i < 8) ? {i[2:0], s[4:0]} : s[7:0];
      if (i == 8) {a, w} = 16'h39FF;
      if (i == 9) {a, w} = 16'h3947;
      if (i == 10) {a, w} = 16'h3B39;
      if (i == 11) {a, w} = 16'h3BFF;
      if (i == 12) {a, w} = 16'h3946;
      if (i == 13) {a, w} = 16'h3B38;
      host.wr(a, w);
      mdl[a[1:0]] = stored(a, w);
      rchk(a);
    end
    // Command restores all but the bypass bit and beats a write in the same cycle
    host.wr(8'h3B, 8'h40);
    fork
      host.wr(8'h39, 8'h01);
      begin
        @(negedge clk_i);
        reg_reset_i = 1'b1;
        @(negedge clk_i);
        reg_reset_i = 1'b0;
      end
    join
    mdl = '{8'h00, 8'h3E, 8'h48, 8'h54};
    for (int i = 1; i < 4; i++) rchk(8'h38 + 8'(i));
    // Frozen clock enable drops the write
    @(negedge clk_i);
    ce_i = 1'b0;
    host.wr(8'h39, 8'h01);
    ce_i = 1'b1;
    rchk(8'h39);
    por();
    good = 1'b0;
    rchk(8'h3B);
    close_out();
  end
endmodule // rail_control_regs_tb
`default_nettype wire
